// File: core/sbsram_pkg.sv
// Package: constants and types of the synchronous burst SRAM interface
package sbsram_pkg;
    // ==========================================================
    // Geometry
    localparam int ADDR_W_DEF   = 17;
    localparam int LANES_DEF    = 4;
    localparam int LANE_W_DEF   = 9;
    localparam int FIFO_DEPTH   = 32;
    // ==========================================================
    // Burst
    localparam int BURST_LEN    = 4;
    localparam int BURST_IDX_W  = 2;
    localparam logic [1:0] BURST_CNT_RST = 2'h0;
    // ==========================================================
    // Data phase kinds, one-hot
    typedef enum logic [2:0] {
        SBSRAM_PH_IDLE  = 3'h1,
        SBSRAM_PH_READ  = 3'h2,
        SBSRAM_PH_WRITE = 3'h4
    } sbsram_phase_t;
endpackage : sbsram_pkg

// File: core/sbsram_fifo.sv
// FIFO: parameterised buffer for completed write words
`timescale 1ns/1ps
module sbsram_fifo
    import sbsram_pkg::*;
#(
    parameter int WIDTH = 36,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // ==========================================================
    // Flags and pointers
    always_comb begin
        in_ready    = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
        out_valid   = wr_ptr != rd_ptr;
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    assign out_data = mem[rd_ptr[AW-1:0]];
endmodule : sbsram_fifo

// File: core/sbsram_burst_addr.sv
// Burst address generator: linear or interleaved two-bit sequence
`timescale 1ns/1ps
module sbsram_burst_addr
    import sbsram_pkg::*;
(
    input  wire logic [BURST_IDX_W-1:0] base_low,
    input  wire logic [BURST_IDX_W-1:0] beat,
    input  wire logic                   linear_order,
    output logic      [BURST_IDX_W-1:0] addr_low
);
    // Linear adds the beat, interleaved xors it
    always_comb begin
        if (linear_order) begin
            addr_low = base_low + beat;
        end else begin
            addr_low = base_low ^ beat;
        end
    end
endmodule : sbsram_burst_addr

// File: core/sbsram_core.sv
// Core: synchronous pipelined burst SRAM device logic
// Function
// - Burst steps two low address bits through four words in selected order.
// - Load low ends any burst and, when selected, captures new address and control.
// - Read/write select ignored while advancing a burst.
// - Burst direction fixed by read/write select captured on load.
// - Write starts when read/write select sampled low on a load.
// - Byte enables lead data by one cycle; applied to next data word.
// - Clock-gate high edge is ignored by the sequencing logic only.
// - Control, burst and data-phase registers hold on a gated edge; pin synchronisers and write buffer keep running.
// - Any chip select inactive on a load starts deselect; no new operation.
// - Data bus goes high impedance one cycle after deselect edge.
// - Deselect lets captured reads and writes finish their data phase.
// - One select active high, two active low; all must be active.
// - Undriven burst-order input behaves as held high.
`timescale 1ns/1ps
module sbsram_core
    import sbsram_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF,
    parameter int LANE_W = LANE_W_DEF
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic [ADDR_W-1:0]         address,
    input  wire logic                      chip_select_a_n,
    input  wire logic                      chip_select_b,
    input  wire logic                      chip_select_c_n,
    input  wire logic                      advance_or_load,
    input  wire logic                      read_write_n,
    input  wire logic [LANES-1:0]          byte_lane_write_n,
    input  wire logic                      clock_gate_n,
    input  wire logic                      burst_order_select_n,
    input  wire logic                      burst_order_driven,
    input  wire logic                      output_enable_n,
    input  wire logic [LANES*LANE_W-1:0]   data_in,
    output logic      [LANES*LANE_W-1:0]   data_out,
    output logic                           data_out_en_n,
    output logic                           wr_valid,
    input  wire logic                      wr_ready,
    output logic      [ADDR_W-1:0]         wr_addr,
    output logic      [LANES*LANE_W-1:0]   wr_data,
    output logic      [LANES-1:0]          wr_lanes,
    output logic                           rd_req,
    output logic      [ADDR_W-1:0]         rd_addr,
    input  wire logic [LANES*LANE_W-1:0]   rd_data,
    output logic                           busy_stall
);
    localparam int DW = LANES * LANE_W;
    localparam int FW = ADDR_W + LANES + DW;
    initial begin
        if (ADDR_W < BURST_IDX_W + 1 || LANES < 1 || LANE_W < 1) $error("Bad geometry");
    end

    // ==========================================================
    // Pin synchronisers (two flops each); output enable stays asynchronous
    localparam int SW = ADDR_W + 6 + LANES + 2 + DW;
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {address, chip_select_a_n, chip_select_b, chip_select_c_n, advance_or_load,
                       read_write_n, clock_gate_n, byte_lane_write_n,
                       burst_order_select_n, burst_order_driven, data_in};
            sync_b <= sync_a;
        end
    end

    logic [ADDR_W-1:0] s_addr;
    logic              s_cs_a_n;
    logic              s_cs_b;
    logic              s_cs_c_n;
    logic              s_adv;
    logic              s_rw_n;
    logic              s_gate_n;
    logic [LANES-1:0]  s_bw_n;
    logic              s_order_n;
    logic              s_order_drv;
    logic [DW-1:0]     s_din;
    assign {s_addr, s_cs_a_n, s_cs_b, s_cs_c_n, s_adv, s_rw_n, s_gate_n, s_bw_n,
            s_order_n, s_order_drv, s_din} = sync_b;

    // ==========================================================
    // Control state
    logic [ADDR_W-1:0]       base_addr;
    logic [BURST_IDX_W-1:0]  beat;
    logic                    burst_active;
    logic                    burst_write;
    sbsram_phase_t           phase;
    logic [ADDR_W-1:0]       phase_addr;
    logic [LANES-1:0]        phase_lanes;
    logic [DW-1:0]           read_word;
    logic                    drive;

    logic [ADDR_W-1:0]       next_base_addr;
    logic [BURST_IDX_W-1:0]  next_beat;
    logic                    next_burst_active;
    logic                    next_burst_write;
    sbsram_phase_t           next_phase;
    logic [ADDR_W-1:0]       next_phase_addr;
    logic [LANES-1:0]        next_phase_lanes;
    logic [DW-1:0]           next_read_word;
    logic                    next_drive;

    logic                    selected;
    logic                    linear_order;
    logic                    edge_live;
    logic                    push_write;
    logic                    fifo_ready;
    logic [BURST_IDX_W-1:0]  step_low;
    logic [BURST_IDX_W-1:0]  next_beat_inc;

    assign selected     = !s_cs_a_n && s_cs_b && !s_cs_c_n;
    assign linear_order = !s_order_drv || s_order_n;
    // Write buffer full stalls like a gated edge while a write data phase is pending
    assign edge_live    = !s_gate_n && !(phase == SBSRAM_PH_WRITE && !fifo_ready);
    assign busy_stall   = !fifo_ready;
    assign next_beat_inc = beat + 1'b1;

    sbsram_burst_addr u_burst_addr (
        .base_low     (base_addr[BURST_IDX_W-1:0]),
        .beat         (next_beat_inc),
        .linear_order (linear_order),
        .addr_low     (step_low)
    );

    // ==========================================================
    // Address, burst and data-phase sequencing
    always_comb begin
        next_base_addr    = base_addr;
        next_beat         = beat;
        next_burst_active = burst_active;
        next_burst_write  = burst_write;
        next_phase        = phase;
        next_phase_addr   = phase_addr;
        next_phase_lanes  = phase_lanes;
        next_read_word    = read_word;
        next_drive        = drive;
        push_write        = 1'b0;
        if (edge_live) begin
            // Finish the data phase captured on the previous edge
            push_write = (phase == SBSRAM_PH_WRITE);
            next_read_word = rd_data;
            if (!s_adv) begin
                next_burst_active = 1'b0;
                if (selected) begin
                    next_base_addr    = s_addr;
                    next_beat         = BURST_CNT_RST;
                    next_burst_active = 1'b1;
                    next_burst_write  = !s_rw_n;
                    next_phase        = s_rw_n ? SBSRAM_PH_READ : SBSRAM_PH_WRITE;
                    next_phase_addr   = s_addr;
                end else begin
                    next_phase = SBSRAM_PH_IDLE;
                end
            end else if (burst_active && beat != 2'(BURST_LEN - 1)) begin
                // Read/write select not consulted here
                next_beat       = next_beat_inc;
                next_phase      = burst_write ? SBSRAM_PH_WRITE : SBSRAM_PH_READ;
                next_phase_addr = {base_addr[ADDR_W-1:BURST_IDX_W], step_low};
            end else begin
                next_burst_active = 1'b0;
                next_phase        = SBSRAM_PH_IDLE;
            end
            next_phase_lanes = ~s_bw_n;
            // Drive while the word of the previous edge's read stands
            next_drive = (phase == SBSRAM_PH_READ);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            base_addr    <= '0;
            beat         <= BURST_CNT_RST;
            burst_active <= 1'b0;
            burst_write  <= 1'b0;
            phase        <= SBSRAM_PH_IDLE;
            phase_addr   <= '0;
            phase_lanes  <= '0;
            read_word    <= '0;
            drive        <= 1'b0;
        end else begin
            base_addr    <= next_base_addr;
            beat         <= next_beat;
            burst_active <= next_burst_active;
            burst_write  <= next_burst_write;
            phase        <= next_phase;
            phase_addr   <= next_phase_addr;
            phase_lanes  <= next_phase_lanes;
            read_word    <= next_read_word;
            drive        <= next_drive;
        end
    end

    // ==========================================================
    // Memory-side ports and write buffer
    assign rd_req  = (phase == SBSRAM_PH_READ);
    assign rd_addr = phase_addr;

    sbsram_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (push_write),
        .in_ready  (fifo_ready),
        .in_data   ({phase_addr, phase_lanes, s_din}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_addr, wr_lanes, wr_data})
    );

    // ==========================================================
    // Data outputs; output enable gates asynchronously to the core
    assign data_out      = read_word;
    assign data_out_en_n = !drive || output_enable_n;
endmodule : sbsram_core

// File: dv/sbsram_core_properties.sv
// Checker: port-level properties of the burst SRAM core
`timescale 1ns/1ps
module sbsram_core_properties
    import sbsram_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF,
    parameter int LANE_W = LANE_W_DEF
) (
    input wire logic                    core_clk,
    input wire logic                    reset,
    input wire logic                    chip_select_a_n,
    input wire logic                    chip_select_b,
    input wire logic                    chip_select_c_n,
    input wire logic                    advance_or_load,
    input wire logic                    clock_gate_n,
    input wire logic                    output_enable_n,
    input wire logic [LANES*LANE_W-1:0] data_out,
    input wire logic                    data_out_en_n,
    input wire logic                    wr_valid,
    input wire logic                    wr_ready,
    input wire logic [ADDR_W-1:0]       wr_addr,
    input wire logic [LANES*LANE_W-1:0] wr_data,
    input wire logic                    rd_req,
    input wire logic [ADDR_W-1:0]       rd_addr,
    input wire logic [LANES*LANE_W-1:0] rd_data,
    input wire logic                    busy_stall
);
    // ==========================================================
    // Sequences
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic desel;
    assign desel = chip_select_a_n | ~chip_select_b | chip_select_c_n;
    sequence live_s; !clock_gate_n [*4]; endsequence
    sequence read_s; live_s ##0 rd_req; endsequence
    sequence off_s; (desel && !advance_or_load && !clock_gate_n) [*6]; endsequence
    // ==========================================================
    // Properties
    wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
        else $error("write word changed while stalled");
    gate_hold_a: assert property (clock_gate_n |-> ##3 $stable({rd_req, rd_addr, data_out}))
        else $error("state moved on a gated edge");
    desel_hiz_a: assert property (off_s |-> data_out_en_n)
        else $error("bus driven while deselected");
    desel_idle_a: assert property (off_s |-> !rd_req)
        else $error("read started while deselected");
    oe_off_a: assert property (output_enable_n [*3] |-> data_out_en_n)
        else $error("bus driven with output enable off");
    rd_word_a: assert property (read_s |=> data_out == $past(rd_data))
        else $error("read word not latched on next edge");
    rd_step_a: assert property (read_s ##0 ($past(rd_req) && $past(advance_or_load, 3))
        |-> rd_addr[ADDR_W-1:2] == $past(rd_addr[ADDR_W-1:2]) && rd_addr[1:0] != $past(rd_addr[1:0]))
        else $error("burst address step wrong");
    full_data_a: assert property (busy_stall |-> wr_valid)
        else $error("full buffer shows no word");
endmodule : sbsram_core_properties

bind sbsram_core sbsram_core_properties #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_props (
    .core_clk(core_clk), .reset(reset), .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
    .chip_select_c_n(chip_select_c_n), .advance_or_load(advance_or_load), .clock_gate_n(clock_gate_n),
    .output_enable_n(output_enable_n), .data_out(data_out), .data_out_en_n(data_out_en_n),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .busy_stall(busy_stall));

// File: dv/sbsram_mem_model.sv
// Partner: memory side behind the write buffer and read port
`timescale 1ns/1ps
module sbsram_mem_model
    import sbsram_pkg::*;
(
    input  wire logic                            core_clk,
    input  wire logic                            reset,
    input  wire logic [1:0]                      hold_mode,
    input  wire logic                            rd_req,
    input  wire logic [ADDR_W_DEF-1:0]           rd_addr,
    output logic                                 wr_ready,
    output logic      [LANES_DEF*LANE_W_DEF-1:0] rd_data
);
    logic tog;
    logic next_tog;
    // ==========================================================
    // Slow answers; idle read line keeps changing
    always_comb begin
        next_tog = ~tog;
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) tog <= 1'b0;
        else tog <= next_tog;
    end
    assign wr_ready = (hold_mode == 2'h0) || (hold_mode == 2'h2 && tog);
    assign rd_data  = rd_req ? {rd_addr, ~rd_addr, 2'h3} : {36{tog}};
endmodule : sbsram_mem_model

// File: dv/sbsram_core_tb_top.sv
// Testbench: bursts, gating, deselect and buffer fill
`timescale 1ns/1ps
module sbsram_core_tb_top
    import sbsram_pkg::*;
;
    localparam int DW = LANES_DEF * LANE_W_DEF;
    logic core_clk = 1'b0, reset = 1'b1, chip_select_a_n = 1'b0, chip_select_b = 1'b0, chip_select_c_n = 1'b0;
    logic advance_or_load = 1'b0, read_write_n = 1'b1, clock_gate_n = 1'b0, output_enable_n = 1'b0;
    logic burst_order_select_n = 1'b1, burst_order_driven = 1'b1;
    logic [16:0] address = 17'h0, pa, base, rd_addr, wr_addr, a, ra;
    logic [3:0] byte_lane_write_n = 4'hF, pl, wr_lanes;
    logic [DW-1:0] data_in = '0, data_out, wr_data, rd_data, rd_exp;
    logic [1:0] hold_mode = 2'h0;
    logic data_out_en_n, wr_valid, wr_ready, rd_req, busy_stall, pw = 0, act = 0, crw = 1, rd_pend = 0;
    logic [31:0] seed = 32'h54;
    logic [56:0] wq[$];
    logic [16:0] rq[$];
    int n_mismatch = 0, checked = 0, beat = 0;
    always #10 core_clk = ~core_clk;
    sbsram_core dut (.core_clk(core_clk), .reset(reset), .address(address), .chip_select_a_n(chip_select_a_n),
        .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n), .advance_or_load(advance_or_load),
        .read_write_n(read_write_n), .byte_lane_write_n(byte_lane_write_n), .clock_gate_n(clock_gate_n),
        .burst_order_select_n(burst_order_select_n), .burst_order_driven(burst_order_driven),
        .output_enable_n(output_enable_n), .data_in(data_in), .data_out(data_out), .data_out_en_n(data_out_en_n),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .wr_lanes(wr_lanes),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .busy_stall(busy_stall));
    sbsram_mem_model u_mem (.core_clk(core_clk), .reset(reset), .hold_mode(hold_mode), .rd_req(rd_req),
        .rd_addr(rd_addr), .wr_ready(wr_ready), .rd_data(rd_data));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(string nm, logic [63:0] ex, logic [63:0] got);
        checked++;
        if (got !== ex) begin
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic give_verdict();
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Kind 0 load, 1 advance, 2 deselect (variant in v), 3 gated edge
    task automatic step(int k, logic rw = 1'b1, logic [16:0] v = 17'h0);
        logic [DW-1:0] d;
        logic [3:0] l;
        logic [1:0] lo;
        logic lin;
        d = DW'({rnd(), rnd()});
        l = 4'(rnd());
        @(posedge core_clk);
        #1;
        clock_gate_n = (k == 3);
        data_in = d;
        byte_lane_write_n = l;
        if (k == 3) begin
            {chip_select_a_n, chip_select_b, chip_select_c_n, advance_or_load, read_write_n} = 5'(rnd());
            address = 17'(rnd());
            return;
        end
        address = v;
        read_write_n = (k == 0) ? rw : 1'(rnd());
        advance_or_load = (k == 1);
        chip_select_a_n = (k == 2) && v[0];
        chip_select_b = !((k == 2) && v[1]);
        chip_select_c_n = (k == 2) && !v[0] && !v[1];
        if (pw) wq.push_back({pa, d, ~pl});
        pw = 0;
        if (k == 0) begin
            base = v;
            beat = 0;
            act = 1;
            crw = rw;
        end else if (k == 1 && act && beat < 3) beat++;
        else act = 0;
        lin = burst_order_select_n | ~burst_order_driven;
        lo = lin ? 2'(base[1:0] + 2'(beat)) : base[1:0] ^ 2'(beat);
        if (act && !crw) begin
            pw = 1;
            pa = {base[16:2], lo};
            pl = l;
        end
        if (act && crw) rq.push_back({base[16:2], lo});
    endtask : step
    // ==========================================================
    // Monitor
    always @(negedge core_clk) begin
        if (rd_pend) begin
            chk("data_out", rd_exp, data_out);
            chk("data_out_en_n", 64'(output_enable_n), data_out_en_n);
        end
        rd_pend = 0;
        if (rd_req) begin
            ra = rq.size() ? rq.pop_front() : 'x;
            chk("rd_addr", ra, rd_addr);
            rd_pend = 1;
            rd_exp = {ra, ~ra, 2'h3};
        end
        if (wr_valid && wr_ready) chk("wr_word", wq.size() ? wq.pop_front() : 'x, {wr_addr, wr_data, wr_lanes});
    end
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
    // ==========================================================
    // Scenarios
    initial begin
        repeat (12) @(posedge core_clk);
        #1 reset = 1'b0;
        repeat (3) step(2);
        for (int m = 0; m < 4; m++) begin
            {burst_order_driven, burst_order_select_n} = 2'(m);
            a = 17'(rnd());
            step(0, 0, a); step(1); step(3); step(1); step(3); step(1);
            step(0, 1, a); step(1); step(1); step(1); step(1); step(2);
            step(0, 0, 17'(rnd())); step(1); step(0, 1, 17'(rnd())); step(1); step(2);
        end
        for (int v = 0; v < 4; v++) begin
            step(0, 1, 17'(rnd())); repeat (6) step(2, 1, 17'(v));
            chk("drive_off", 64'h1, data_out_en_n);
        end
        output_enable_n = 1'b1;
        step(0, 1, 17'(rnd())); repeat (3) step(1);
        chk("oe_off", 64'h1, data_out_en_n);
        output_enable_n = 1'b0;
        repeat (8) step(2);
        hold_mode = 2'h1;
        repeat (8) begin step(0, 0, 17'(rnd())); repeat (3) step(1); end
        repeat (4) step(2);
        chk("full", 64'h1, busy_stall);
        hold_mode = 2'h2;
        repeat (80) step(2);
        chk("drained", 64'h0, busy_stall);
        chk("left", 64'h0, 64'(wq.size() + rq.size()));
        give_verdict();
    end
endmodule : sbsram_core_tb_top
